//--- rtl/battery_diag_pkg.sv
// Functional notes
// - The high-battery switch threshold is an 8-bit field in bits 14:7 and decides high-supply use.
// - The low-battery switch threshold is an 8-bit field in bits 14:7 and decides low-supply use.
// - Each threshold is compared with the filtered RING voltage plus the overhead voltage.
// - Threshold codes scale at 4.907 mV per LSB, 0 to 160.173 V, 628 mV effective resolution.
// - The RING voltage is low-pass filtered before the battery decision, coefficient in bits 15:3.
// - While tracking is enabled, the RING voltage is filtered with its own 13-bit coefficient.
// - The upper half of the speedup threshold comes from one 16-bit word.
// - The lower half comes from a second 16-bit word and both form one threshold.
// - A 16-bit diagnostic result holds a filtered ac rms value of the monitor ADC output.
// - The monitor ADC input is chosen by the diagnostic selection setting and feeds the result.
// - The ac rms result uses a coefficient from its own programmable word.
// - Reset clears the high threshold, all three filter coefficients, the upper speedup word and the result.
// - Words are two's complement unless stated otherwise, and some accept only positive values.
package battery_diag_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_OVERHEAD = 8'h05;
  localparam logic [7:0] IDX_HIGH_TH = 8'h1f;
  localparam logic [7:0] IDX_LOW_TH = 8'h20;
  localparam logic [7:0] IDX_RING_COEFF = 8'h21;
  localparam logic [7:0] IDX_TRACK_COEFF = 8'h22;
  localparam logic [7:0] IDX_SPEED_LO = 8'h23;
  localparam logic [7:0] IDX_SPEED_HI = 8'h24;
  localparam logic [7:0] IDX_DIAG_AC = 8'h35;
  localparam logic [7:0] IDX_DIAG_COEFF = 8'h36;
  localparam logic [7:0] IDX_MON_SEL = 8'h40;
  localparam logic [7:0] IDX_CONTROL = 8'h41;
  localparam logic [7:0] IDX_STATUS = 8'h42;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_LSB = 2;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int unsigned WORD_W = 16;
  localparam logic [15:0] THRESH_MASK = 16'h7f80;
  localparam logic [15:0] COEFF_MASK = 16'hfff8;
  localparam int unsigned COEFF_LSB = 3;
  localparam int unsigned COEFF_W = 13;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam int unsigned CTRL_TRACK_EN = 0;
  localparam int unsigned STAT_HIGH = 0;
  localparam int unsigned STAT_LOW = 1;

  // ---------------------------------------------------------------
  // Scales and fixed filter settings
  // ---------------------------------------------------------------
  localparam int unsigned THRESH_UV_PER_LSB_X1000 = 4907;
  localparam int unsigned AC_DIAG_MAX_HZ = 300;
  localparam logic [12:0] DC_BLOCK_COEFF = 13'h0010;
  localparam logic [15:0] RMS_SCALE = 16'h8e2b;
  localparam int unsigned RMS_SCALE_SHIFT = 15;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef enum logic [1:0] {
    BAT_LOW = 2'b01,
    BAT_HIGH = 2'b10
  } battery_state_t;

endpackage

//--- rtl/first_order_lpf.sv
`timescale 1ns/1ps
module first_order_lpf #(
  parameter int unsigned W = 16,
  parameter int unsigned CW = 13
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic load,
  input wire logic signed [W-1:0] sample,
  input wire logic signed [W-1:0] load_value,
  input wire logic [CW-1:0] coeff,
  output logic signed [W-1:0] filtered
);

  typedef struct packed {
    logic signed [W-1:0] y;
  } lpf_state_t;

  lpf_state_t s;
  lpf_state_t next_s;
  logic signed [W:0] diff;
  logic signed [W+CW+1:0] prod;
  logic signed [W+CW+1:0] step;
  logic signed [W+1:0] sum;

  generate
    if (W < 2 || CW < 1) begin : g_bad_width
      $error("first_order_lpf: unsupported width");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Step toward the sample by coeff / 2^CW of the gap
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    diff = (W+1)'(sample) - (W+1)'(s.y);
    prod = (W+CW+2)'($signed({1'b0, coeff})) * (W+CW+2)'(diff);
    step = prod >>> CW;
    sum = (W+2)'(s.y) + step[W+1:0];
    if (load) begin
      next_s.y = load_value;
    end else if (enable) begin
      next_s.y = sum[W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign filtered = s.y;

  a_lpf_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load |=> filtered == $past(load_value))
    else $error("filter did not take the loaded value");

  a_lpf_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !enable && !load |=> $stable(filtered))
    else $error("filter moved while idle");

endmodule

//--- rtl/battery_diag_filters.sv
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
module battery_diag_filters
  import battery_diag_pkg::*;
#(
  parameter int unsigned SEL_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire battery_diag_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] ring_sample,
  input wire logic ring_sample_valid,
  input wire logic line_active,
  input wire logic signed [15:0] monitor_sample,
  input wire logic monitor_sample_valid,
  output logic [SEL_W-1:0] monitor_input_select,
  output logic high_battery_selected,
  output logic low_battery_selected,
  output logic signed [15:0] tracked_ring_voltage,
  output logic [31:0] speedup_threshold,
  output logic [15:0] diag_ac_rms
);
  import battery_diag_pkg::*;

  typedef struct packed {
    logic [15:0] high_th;
    logic [15:0] low_th;
    logic [15:0] ring_coeff;
    logic [15:0] track_coeff;
    logic [15:0] speed_lo;
    logic [15:0] speed_hi;
    logic [15:0] diag_coeff;
    logic [15:0] overhead;
    logic [SEL_W-1:0] mon_sel;
    logic track_en;
    battery_state_t bat;
    logic [31:0] rdata;
    logic [31:0] speed_thr;
  } state_t;

  state_t s;
  state_t next_s;
  logic setup;
  logic access;
  logic wr_en;
  logic mapped;
  logic diag_load;
  logic [7:0] idx;
  logic [15:0] rd_word;
  logic [15:0] wdata;
  logic signed [15:0] ring_filt;
  logic signed [15:0] mon_dc;
  logic signed [15:0] rms_in;
  logic signed [16:0] ac_part;
  logic [16:0] ac_mag;
  logic [32:0] rms_prod;
  logic [16:0] rms_scaled;
  logic [16:0] ring_mag;
  logic [15:0] ovh_pos;
  logic [17:0] demand;

  generate
    if (SEL_W < 1 || SEL_W > WORD_W) begin : g_bad_sel
      $error("battery_diag_filters: SEL_W out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Filters
  // ---------------------------------------------------------------
  first_order_lpf #(.W(WORD_W), .CW(COEFF_W)) u_ring_lpf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(ring_sample_valid),
    .load(1'b0),
    .sample(ring_sample),
    .load_value(16'sh0000),
    .coeff(s.ring_coeff[15:COEFF_LSB]),
    .filtered(ring_filt)
  );

  first_order_lpf #(.W(WORD_W), .CW(COEFF_W)) u_track_lpf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(ring_sample_valid && s.track_en),
    .load(1'b0),
    .sample(ring_sample),
    .load_value(16'sh0000),
    .coeff(s.track_coeff[15:COEFF_LSB]),
    .filtered(tracked_ring_voltage)
  );

  // Slow dc estimate so only the ac part reaches the rms path
  first_order_lpf #(.W(WORD_W), .CW(COEFF_W)) u_dc_block (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(monitor_sample_valid),
    .load(1'b0),
    .sample(monitor_sample),
    .load_value(16'sh0000),
    .coeff(DC_BLOCK_COEFF),
    .filtered(mon_dc)
  );

  first_order_lpf #(.W(WORD_W), .CW(COEFF_W)) u_rms_lpf (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .enable(monitor_sample_valid),
    .load(diag_load),
    .sample(rms_in),
    .load_value(wdata),
    .coeff(s.diag_coeff[15:COEFF_LSB]),
    .filtered(diag_ac_rms)
  );

  // ---------------------------------------------------------------
  // Rms estimate: rectified ac scaled to sine rms
  // ---------------------------------------------------------------
  always_comb begin
    ac_part = 17'(monitor_sample) - 17'(mon_dc);
    ac_mag = ac_part[16] ? 17'(-ac_part) : 17'(ac_part);
    rms_prod = 33'(ac_mag) * 33'(RMS_SCALE);
    rms_scaled = rms_prod[RMS_SCALE_SHIFT+16:RMS_SCALE_SHIFT];
    rms_in = (rms_scaled > 17'h07fff) ? 16'sh7fff : $signed(rms_scaled[15:0]);
  end

  // ---------------------------------------------------------------
  // Register access and battery decision
  // ---------------------------------------------------------------
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr_en = access && apb_req.pwrite;
  assign idx = apb_req.paddr[IDX_LSB+7:IDX_LSB];
  assign wdata = apb_req.pwdata[15:0];

  always_comb begin
    next_s = s;
    rd_word = RESET_WORD;
    mapped = 1'b1;
    diag_load = 1'b0;
    if (idx == IDX_OVERHEAD) begin
      rd_word = s.overhead;
      if (wr_en) next_s.overhead = wdata;
    end else if (idx == IDX_HIGH_TH) begin
      rd_word = s.high_th;
      if (wr_en) next_s.high_th = wdata & THRESH_MASK;
    end else if (idx == IDX_LOW_TH) begin
      rd_word = s.low_th;
      if (wr_en) next_s.low_th = wdata & THRESH_MASK;
    end else if (idx == IDX_RING_COEFF) begin
      rd_word = s.ring_coeff;
      if (wr_en) next_s.ring_coeff = wdata & COEFF_MASK;
    end else if (idx == IDX_TRACK_COEFF) begin
      rd_word = s.track_coeff;
      if (wr_en) next_s.track_coeff = wdata & COEFF_MASK;
    end else if (idx == IDX_SPEED_LO) begin
      rd_word = s.speed_lo;
      if (wr_en) next_s.speed_lo = wdata;
    end else if (idx == IDX_SPEED_HI) begin
      rd_word = s.speed_hi;
      if (wr_en) next_s.speed_hi = wdata;
    end else if (idx == IDX_DIAG_AC) begin
      rd_word = diag_ac_rms;
      diag_load = wr_en;
    end else if (idx == IDX_DIAG_COEFF) begin
      rd_word = s.diag_coeff;
      if (wr_en) next_s.diag_coeff = wdata & COEFF_MASK;
    end else if (idx == IDX_MON_SEL) begin
      rd_word = 16'(s.mon_sel);
      if (wr_en) next_s.mon_sel = wdata[SEL_W-1:0];
    end else if (idx == IDX_CONTROL) begin
      rd_word[CTRL_TRACK_EN] = s.track_en;
      if (wr_en) next_s.track_en = wdata[CTRL_TRACK_EN];
    end else if (idx == IDX_STATUS) begin
      rd_word[STAT_HIGH] = (s.bat == BAT_HIGH);
      rd_word[STAT_LOW] = (s.bat == BAT_LOW);
    end else begin
      mapped = 1'b0;
    end
    if (setup) begin
      next_s.rdata = {16'h0000, rd_word};
    end
    next_s.speed_thr = {s.speed_hi, s.speed_lo};

    // Demand = |filtered RING| + positive overhead
    ring_mag = ring_filt[15] ? 17'(-17'(ring_filt)) : 17'(ring_filt);
    ovh_pos = s.overhead[15] ? RESET_WORD : s.overhead;
    demand = 18'(ring_mag) + 18'(ovh_pos);
    if (line_active) begin
      case (s.bat)
        BAT_LOW: begin
          if (demand >= 18'(s.high_th)) next_s.bat = BAT_HIGH;
        end
        BAT_HIGH: begin
          if (demand < 18'(s.low_th) && demand < 18'(s.high_th)) begin
            next_s.bat = BAT_LOW;
          end
        end
        default: begin
          next_s.bat = BAT_HIGH;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.bat <= BAT_HIGH;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = s.rdata;
  assign monitor_input_select = s.mon_sel;
  assign high_battery_selected = (s.bat == BAT_HIGH);
  assign low_battery_selected = (s.bat == BAT_LOW);
  assign speedup_threshold = s.speed_thr;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_high_th_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_HIGH_TH |=> s.high_th == ($past(wdata) & THRESH_MASK))
    else $error("high threshold field wrong after write");

  a_low_th_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_LOW_TH |=> s.low_th == ($past(wdata) & THRESH_MASK))
    else $error("low threshold field wrong after write");

  a_switch_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_active && demand >= 18'(s.high_th) |=> high_battery_selected)
    else $error("high battery not selected above threshold");

  a_switch_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
    line_active && high_battery_selected && demand < 18'(s.low_th)
      && demand < 18'(s.high_th) |=> low_battery_selected)
    else $error("low battery not selected below threshold");

  a_hold_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !line_active |=> $stable(s.bat))
    else $error("battery changed outside active mode");

  a_coeff_low_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_RING_COEFF |=> s.ring_coeff[2:0] == 3'h0
      && s.ring_coeff[15:3] == $past(wdata[15:3]))
    else $error("coefficient low bits not dropped");

  a_track_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !s.track_en |=> $stable(tracked_ring_voltage))
    else $error("tracking filter moved while disabled");

  a_speed_words: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_SPEED_LO |=> ##1 speedup_threshold[15:0] == $past(wdata, 2))
    else $error("speedup threshold low half not combined");

  a_mon_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_MON_SEL |=> monitor_input_select == $past(wdata[SEL_W-1:0]))
    else $error("monitor select not updated");

  a_diag_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_DIAG_AC |=> diag_ac_rms == $past(wdata))
    else $error("diag result not loaded by write");

  a_reset_zero: assert property (@(posedge ref_clk)
    !rst_n |=> s.high_th == RESET_WORD && s.ring_coeff == RESET_WORD
      && s.track_coeff == RESET_WORD && s.speed_hi == RESET_WORD
      && diag_ac_rms == RESET_WORD)
    else $error("reset values not zero");

  a_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
    setup && idx == IDX_HIGH_TH |=> prdata == {16'h0000, $past(s.high_th)})
    else $error("read data wrong");

  a_one_battery: assert property (@(posedge ref_clk) disable iff (!rst_n)
    high_battery_selected != low_battery_selected)
    else $error("battery selection not one-hot");

  a_speed_hi_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_SPEED_HI |=> ##1 speedup_threshold[31:16] == $past(wdata, 2))
    else $error("speedup threshold high half not combined");

  a_track_coeff_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_TRACK_COEFF |=> s.track_coeff == ($past(wdata) & COEFF_MASK))
    else $error("tracking coefficient field wrong after write");

  a_diag_coeff_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && idx == IDX_DIAG_COEFF |=> s.diag_coeff == ($past(wdata) & COEFF_MASK))
    else $error("diag coefficient field wrong after write");

  c_go_low: cover property (@(posedge ref_clk) disable iff (!rst_n)
    high_battery_selected ##1 low_battery_selected);
  c_go_high: cover property (@(posedge ref_clk) disable iff (!rst_n)
    low_battery_selected ##1 high_battery_selected);
  c_diag_moves: cover property (@(posedge ref_clk) disable iff (!rst_n)
    monitor_sample_valid ##1 $changed(diag_ac_rms));
  c_bad_addr: cover property (@(posedge ref_clk) disable iff (!rst_n) pslverr);

endmodule

//--- bench/line_adc_model.sv
`timescale 1ns/1ps
module line_adc_model #(
  parameter int SPACING = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic signed [15:0] ring_level,
  input wire logic signed [15:0] mon_amp,
  output logic signed [15:0] ring_sample,
  output logic ring_sample_valid,
  output logic signed [15:0] monitor_sample,
  output logic monitor_sample_valid
);
  int cnt;
  logic sign;
  // --------------------------------
  // Sample pacing, junk between samples
  // --------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt <= 0;
      sign <= 1'b0;
      ring_sample <= 16'h0000;
      monitor_sample <= 16'h0000;
      ring_sample_valid <= 1'b0;
      monitor_sample_valid <= 1'b0;
    end else begin
      cnt <= (cnt == SPACING - 1) ? 0 : cnt + 1;
      ring_sample_valid <= (cnt == 0);
      monitor_sample_valid <= (cnt == 0);
      if (cnt == 0) begin
        ring_sample <= ring_level;
        monitor_sample <= sign ? -mon_amp : mon_amp;
        sign <= ~sign;
      end else begin
        ring_sample <= ~ring_sample;
        monitor_sample <= ~monitor_sample;
      end
    end
  end
endmodule

//--- bench/test_battery_switch_diag_filters.sv
`timescale 1ns/1ps
module test_battery_switch_diag_filters;
  import battery_diag_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_t apb_req = '0;
  logic line_active = 1'b0;
  logic signed [15:0] ring_level = 16'h0000;
  logic signed [15:0] mon_amp = 16'h0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic signed [15:0] ring_sample;
  logic ring_sample_valid;
  logic signed [15:0] monitor_sample;
  logic monitor_sample_valid;
  logic [3:0] monitor_input_select;
  logic high_battery_selected;
  logic low_battery_selected;
  logic signed [15:0] tracked_ring_voltage;
  logic [31:0] speedup_threshold;
  logic [15:0] diag_ac_rms;
  int miscompares = 0;
  int n_compared = 0;
  int seed = 93398;
  int n;
  logic [31:0] rd;
  logic err;
  logic [15:0] v;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [7:0] regs [8] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h36, 8'h35};

  always #2 ref_clk = ~ref_clk;

  battery_diag_filters battery_diag_filters_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ring_sample(ring_sample), .ring_sample_valid(ring_sample_valid),
    .line_active(line_active), .monitor_sample(monitor_sample),
    .monitor_sample_valid(monitor_sample_valid), .monitor_input_select(monitor_input_select),
    .high_battery_selected(high_battery_selected), .low_battery_selected(low_battery_selected),
    .tracked_ring_voltage(tracked_ring_voltage), .speedup_threshold(speedup_threshold),
    .diag_ac_rms(diag_ac_rms));

  line_adc_model line_adc_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .ring_level(ring_level), .mon_amp(mon_amp), .ring_sample(ring_sample),
    .ring_sample_valid(ring_sample_valid), .monitor_sample(monitor_sample),
    .monitor_sample_valid(monitor_sample_valid));

  // --------------------------------
  // Helpers
  // --------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int k;
    k = 0;
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= {2'h0, idx, 2'h0};
    apb_req.pwdata <= {16'h0000, d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  function automatic logic [15:0] mask(input logic [7:0] idx);
    if (idx == IDX_HIGH_TH || idx == IDX_LOW_TH) begin
      return THRESH_MASK;
    end
    if (idx == IDX_RING_COEFF || idx == IDX_TRACK_COEFF || idx == IDX_DIAG_COEFF) begin
      return COEFF_MASK;
    end
    return 16'hffff;
  endfunction

  task automatic wait_bat(input logic exp_high);
    n = 0;
    while (high_battery_selected !== exp_high && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    check("high_sel", high_battery_selected, exp_high);
    check("low_sel", low_battery_selected, !exp_high);
    xfer(1'b0, IDX_STATUS, 16'h0000);
    check("status", rd, exp_high ? 32'h1 : 32'h2);
  endtask

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      xfer(1'b0, regs[i], 16'h0000);
      check("reset_val", rd, 32'h0);
    end
    repeat (4) for (int i = 0; i < 7; i++) begin
      v = $random(seed);
      xfer(1'b1, regs[i], v);
      xfer(1'b0, regs[i], 16'h0000);
      check("rw_mask", rd, {16'h0000, v & mask(regs[i])});
    end
    hi = $random(seed);
    lo = $random(seed);
    xfer(1'b1, IDX_SPEED_HI, hi);
    xfer(1'b1, IDX_SPEED_LO, lo);
    @(posedge ref_clk);
    check("speedup", speedup_threshold, {hi, lo});
    xfer(1'b1, 8'h10, 16'hffff);
    check("unmapped_err", err, 1'b1);
    xfer(1'b0, 8'h10, 16'h0000);
    check("unmapped_rd", rd, 32'h0);
    xfer(1'b0, IDX_HIGH_TH, 16'h0000);
    check("mapped_err", err, 1'b0);
    v = $random(seed);
    xfer(1'b1, IDX_MON_SEL, v);
    check("mon_sel", monitor_input_select, v[3:0]);
    xfer(1'b1, IDX_HIGH_TH, 16'h4000);
    xfer(1'b1, IDX_LOW_TH, 16'h2000);
    xfer(1'b1, IDX_RING_COEFF, 16'hfff8);
    xfer(1'b1, IDX_OVERHEAD, 16'h0000);
    line_active <= 1'b1;
    ring_level <= 16'sh1000;
    wait_bat(1'b0);
    ring_level <= 16'sh5000;
    wait_bat(1'b1);
    ring_level <= 16'sh1000;
    wait_bat(1'b0);
    xfer(1'b1, IDX_OVERHEAD, 16'h3000);
    wait_bat(1'b1);
    xfer(1'b1, IDX_OVERHEAD, 16'h2fff);
    repeat (40) @(posedge ref_clk);
    wait_bat(1'b1);
    xfer(1'b1, IDX_OVERHEAD, 16'h8000);
    wait_bat(1'b0);
    line_active <= 1'b0;
    ring_level <= 16'sh5000;
    repeat (40) @(posedge ref_clk);
    wait_bat(1'b0);
    line_active <= 1'b1;
    xfer(1'b1, IDX_TRACK_COEFF, 16'hfff8);
    xfer(1'b1, IDX_CONTROL, 16'h0001);
    n = 0;
    while (!(tracked_ring_voltage >= 16'sh4ff0 && tracked_ring_voltage <= 16'sh5000)
           && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    check("tracked", n < 1000, 1'b1);
    xfer(1'b1, IDX_DIAG_COEFF, 16'h0000);
    xfer(1'b1, IDX_DIAG_AC, 16'h1234);
    xfer(1'b0, IDX_DIAG_AC, 16'h0000);
    check("diag_rd", rd, 32'h1234);
    check("diag_out", diag_ac_rms, 16'h1234);
    mon_amp <= 16'sh1000;
    xfer(1'b1, IDX_DIAG_COEFF, 16'hfff8);
    n = 0;
    v = 16'((32'h1000 * RMS_SCALE) >> RMS_SCALE_SHIFT);
    while (!(diag_ac_rms >= v - 16'd60 && diag_ac_rms <= v + 16'd60) && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    check("diag_rms", n < 3000, 1'b1);
    tally_and_finish;
  end

  initial begin
    #(4 * 40000);
    miscompares++;
    tally_and_finish;
  end
endmodule
